// File: bench/module_stop_deep_standby_ctrl_tb.sv
`timescale 1ns/1ps
`include "mstp_dsby_params.svh"
module module_stop_deep_standby_ctrl_tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0;
   logic deep_standby_active = 1'b0;
   logic [3:0] deep_wake_pin = 4'h0;
   logic [7:0] other_wake_src = 8'h00;
   logic [2:0] vmon_reset_pulse = 3'h0;
   logic [31:0] hrdata, clk_en_a, clk_en_b, clk_en_c, q;
   logic hreadyout, hresp, mac_clk_en, mac_dma_clk_en, deep_wake_release;
   logic sram_usb_power_on, vdet_stop, por_low_power, irq;
   logic [31:0] cut_rd[4] = '{32'h0, 32'h1, 32'h1, 32'h3};
   logic [31:0] cut_out[4] = '{32'h4, 32'h0, 32'h0, 32'h3};
   int bits_b[10] = '{0, 1, 4, 6, 8, 9, 15, 22, 24, 27};
   int bits_c[9] = '{7, 17, 19, 22, 23, 24, 25, 26, 27};
   int n_errors = 0;
   int n_checks = 0;
   int i;
   module_stop_deep_standby_ctrl module_stop_deep_standby_ctrl_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .clk_en_a(clk_en_a),
      .clk_en_b(clk_en_b), .clk_en_c(clk_en_c), .mac_clk_en(mac_clk_en),
      .mac_dma_clk_en(mac_dma_clk_en), .deep_standby_active(deep_standby_active),
      .deep_wake_pin(deep_wake_pin), .other_wake_src(other_wake_src),
      .deep_wake_release(deep_wake_release), .sram_usb_power_on(sram_usb_power_on),
      .vdet_stop(vdet_stop), .por_low_power(por_low_power),
      .vmon_reset_pulse(vmon_reset_pulse), .irq(irq)
   );
   initial forever #2.5 hclk = ~hclk;
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic edge_rdy();
      int k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 16);
      if (hreadyout !== 1'b1) begin
         n_errors++;
         finish_test();
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      edge_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      edge_rdy();
      q = hrdata;
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e, input string n);
      xfer(1'b0, a, 32'h0);
      chk(n, e, q);
   endtask
   task automatic stop_bit(input logic [11:0] a, input int b);
      logic [31:0] m;
      m = 32'h1 << b;
      xfer(1'b1, a, ~m);
      tick(2);
      chk("clock enable", m, (a == `OFS_STOP_B) ? clk_en_b : clk_en_c);
      chk("mac pair", {30'h0, {2{m[15] && a == `OFS_STOP_B}}}, {30'h0, mac_clk_en, mac_dma_clk_en});
      rc(a, ~m, "stop readback");
      xfer(1'b1, a, 32'hFFFF_FFFF);
      tick(2);
      chk("clock frozen", 32'h0, (a == `OFS_STOP_B) ? clk_en_b : clk_en_c);
   endtask
   task automatic wait_rel(input logic e);
      logic seen = 1'b0;
      repeat (12) begin
         @(posedge hclk);
         seen = seen | (deep_wake_release === 1'b1);
      end
      chk("wake release", {31'h0, e}, {31'h0, seen});
   endtask
   initial begin
      tick(16);
      hresetn <= 1'b1;
      tick(1);
      rc(`OFS_STOP_A, `RST_STOP_A, "stop a reset");
      rc(`OFS_STOP_B, `RST_STOP_B, "stop b reset");
      rc(`OFS_STOP_C, `RST_STOP_C, "stop c reset");
      chk("okay response", 32'h0, {31'h0, hresp});
      xfer(1'b1, 12'h100, 32'hFFFF_FFFF);
      rc(12'h100, 32'h0, "unmapped");
      xfer(1'b1, `OFS_STOP_A, 32'h0);
      tick(2);
      chk("stop a enables", 32'hFFFF_FFFF, clk_en_a);
      foreach (bits_b[j]) stop_bit(`OFS_STOP_B, bits_b[j]);
      foreach (bits_c[j]) stop_bit(`OFS_STOP_C, bits_c[j]);
      tick(2);
      deep_standby_active <= 1'b1;
      for (i = 0; i < 4; i++) begin
         xfer(1'b1, `OFS_DSBY_CTRL, 32'(i));
         tick(2);
         rc(`OFS_DSBY_CTRL, cut_rd[i], "deep cut");
         chk("power outs", cut_out[i], {29'h0, sram_usb_power_on, vdet_stop, por_low_power});
      end
      for (i = 0; i < 3; i++) begin
         vmon_reset_pulse <= 3'h1 << i;
         tick(1);
         vmon_reset_pulse <= 3'h0;
         tick(2);
         rc(`OFS_RESET_STATUS, 32'h2 << i, "vmon flag");
         xfer(1'b1, `OFS_RESET_STATUS, 32'h2 << i);
      end
      chk("irq masked", 32'h0, {31'h0, irq});
      xfer(1'b1, `OFS_IRQ_MASK, 32'h1);
      tick(2);
      chk("irq raised", 32'h1, {31'h0, irq});
      xfer(1'b1, `OFS_IRQ_STATUS, 32'h1);
      tick(2);
      chk("irq cleared", 32'h0, {31'h0, irq});
      xfer(1'b1, `OFS_WAKE_EN0, 32'hD0);
      xfer(1'b1, `OFS_WAKE_EDGE0, 32'h40);
      deep_wake_pin <= 4'h1;
      wait_rel(1'b1);
      rc(`OFS_WAKE_FLAG0, 32'h10, "pin flag");
      deep_wake_pin <= 4'h3;
      wait_rel(1'b0);
      deep_wake_pin <= 4'h7;
      wait_rel(1'b0);
      deep_wake_pin <= 4'h3;
      wait_rel(1'b1);
      rc(`OFS_WAKE_FLAG0, 32'h50, "pin flags");
      xfer(1'b1, `OFS_WAKE_FLAG0, 32'h50);
      rc(`OFS_WAKE_FLAG0, 32'h0, "flags cleared");
      xfer(1'b1, `OFS_WAKE_EN1, 32'h01);
      other_wake_src <= 8'h01;
      wait_rel(1'b1);
      rc(`OFS_IRQ_STATUS, 32'h6, "irq status");
      finish_test();
   end
endmodule

// File: bench/mstp_dsby_assertions.sv
`timescale 1ns/1ps
`include "mstp_dsby_params.svh"
module mstp_dsby_checker (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Bus address phase.
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   // Watched signals.
   input wire logic [31:0] clk_en_b,
   input wire logic [31:0] clk_en_c,
   input wire logic mac_clk_en,
   input wire logic mac_dma_clk_en,
   input wire logic deep_standby_active,
   input wire logic deep_wake_release,
   input wire logic sram_usb_power_on,
   input wire logic vdet_stop,
   input wire logic por_low_power,
   input wire logic [7:0] other_wake_src
);
   default clocking dc @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   mac_pair_a: assert property (mac_clk_en == mac_dma_clk_en)
      else $error("Mac enables differ.");
   mac_bit_a: assert property (mac_clk_en == clk_en_b[15])
      else $error("Mac enable differs from stop bit.");
   deep_cut_a: assert property (vdet_stop |-> !sram_usb_power_on)
      else $error("Monitor stopped with power kept.");
   por_vdet_a: assert property (por_low_power == vdet_stop)
      else $error("Power-on low power mismatch.");
   awake_power_a: assert property (!$past(deep_standby_active) |-> sram_usb_power_on)
      else $error("Power removed while awake.");
   release_pulse_a: assert property (deep_wake_release
      && $past(other_wake_src, 2) == 8'h00 |=> !deep_wake_release)
      else $error("Release longer than one cycle.");
   stop_b_write_a: assert property ($changed(clk_en_b) |->
      $past(hsel && hwrite && htrans[1] && haddr == `OFS_STOP_B, 2))
      else $error("Stop B enables moved without write.");
   stop_c_write_a: assert property ($changed(clk_en_c) |->
      $past(hsel && hwrite && htrans[1] && haddr == `OFS_STOP_C, 2))
      else $error("Stop C enables moved without write.");
endmodule
bind module_stop_deep_standby_ctrl mstp_dsby_checker checker_inst (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .clk_en_b(clk_en_b), .clk_en_c(clk_en_c), .mac_clk_en(mac_clk_en),
   .mac_dma_clk_en(mac_dma_clk_en), .deep_standby_active(deep_standby_active),
   .deep_wake_release(deep_wake_release), .sram_usb_power_on(sram_usb_power_on),
   .vdet_stop(vdet_stop), .por_low_power(por_low_power),
   .other_wake_src(other_wake_src)
);

// File: hdl/module_stop_deep_standby_ctrl.sv
`timescale 1ns/1ps
`include "mstp_dsby_params.svh"
module module_stop_deep_standby_ctrl (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Peripheral clock enables, high while the peripheral runs.
   output logic [31:0] clk_en_a,
   output logic [31:0] clk_en_b,
   output logic [31:0] clk_en_c,
   output logic mac_clk_en,
   output logic mac_dma_clk_en,
   // Deep standby control.
   input wire logic deep_standby_active,
   input wire logic [3:0] deep_wake_pin,
   input wire logic [7:0] other_wake_src,
   output logic deep_wake_release,
   output logic sram_usb_power_on,
   output logic vdet_stop,
   output logic por_low_power,
   // Voltage monitor reset causes, one-cycle pulses.
   input wire logic [2:0] vmon_reset_pulse,
   // Interrupt.
   output logic irq
);
   typedef struct packed {
      mstp_dsby_pkg::bus_phase_t phase;
      logic [11:0] addr;
      logic [31:0] rdata;
      logic [31:0] stop_a;
      logic [31:0] stop_b;
      logic [31:0] stop_c;
      logic [1:0] deep_cut;
      logic [3:0] wake_en0;
      logic [7:0] wake_en1;
      logic [7:0] wake_en2;
      logic [7:0] wake_en3;
      logic [3:0] wake_flag0;
      logic [3:0] wake_edge0;
      logic [2:0] vmon_flag;
      logic [2:0] irq_status;
      logic [2:0] irq_mask;
      logic [31:0] en_a;
      logic [31:0] en_b;
      logic [31:0] en_c;
      logic mac_en;
      logic dma_en;
      logic release_o;
      logic pwr_on;
      logic vdet_off;
      logic por_lp;
      logic irq_o;
   } ctrl_state_t;

   ctrl_state_t s;
   ctrl_state_t next_s;
   logic [3:0] pin_s;
   logic [3:0] pin_event;
   logic [7:0] other_s;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pin
         pin_sync u_sync (
            .hclk(hclk),
            .hresetn(hresetn),
            .async_in(deep_wake_pin[gi]),
            .sync_out(pin_s[gi])
         );
         wake_detect u_det (
            .hclk(hclk),
            .hresetn(hresetn),
            .pin_sync(pin_s[gi]),
            .edge_sel(s.wake_edge0[gi]),
            .event_pulse(pin_event[gi])
         );
      end
      for (gi = 0; gi < 8; gi++) begin : g_other
         pin_sync u_sync (
            .hclk(hclk),
            .hresetn(hresetn),
            .async_in(other_wake_src[gi]),
            .sync_out(other_s[gi])
         );
      end
   endgenerate

   logic [31:0] wd;
   logic wr;
   logic [3:0] pin_wake;
   logic other_wake;
   logic [2:0] vmon_in;
   logic [2:0] irq_ev;
   logic [31:0] rd;
   logic [1:0] cut_wr;
   logic [31:0] b_run;

   always_comb begin
      next_s = s;
      wd = hwdata;
      wr = (s.phase == mstp_dsby_pkg::PH_WRITE);
      vmon_in = vmon_reset_pulse;
      // Only enabled sources release deep standby, and only while in it.
      pin_wake = pin_event & s.wake_en0 & {4{deep_standby_active}};
      other_wake = deep_standby_active
         & (|(other_s & (s.wake_en1 | s.wake_en2 | s.wake_en3)));
      irq_ev = {|pin_wake, other_wake, |vmon_in};
      cut_wr = wd[1:0];

      // Address phase capture.
      next_s.phase = mstp_dsby_pkg::PH_IDLE;
      if (hsel && hready && htrans[1]) begin
         next_s.addr = haddr;
         next_s.phase = hwrite ? mstp_dsby_pkg::PH_WRITE : mstp_dsby_pkg::PH_READ;
      end

      // Register writes in the data phase.
      if (wr) begin
         unique case (s.addr)
            `OFS_STOP_A: next_s.stop_a = wd;
            `OFS_STOP_B: next_s.stop_b = wd;
            `OFS_STOP_C: next_s.stop_c = wd;
            `OFS_DSBY_CTRL: begin
               // The forbidden code is refused; the old setting stays.
               if (cut_wr != mstp_dsby_pkg::CUT_BAD) begin
                  next_s.deep_cut = cut_wr;
               end
            end
            `OFS_WAKE_EN0: next_s.wake_en0 = wd[`WAKE_HI:`WAKE_LO];
            `OFS_WAKE_EN1: next_s.wake_en1 = wd[7:0];
            `OFS_WAKE_EN2: next_s.wake_en2 = wd[7:0];
            `OFS_WAKE_EN3: next_s.wake_en3 = wd[7:0];
            `OFS_WAKE_FLAG0: next_s.wake_flag0 = s.wake_flag0 & ~wd[`WAKE_HI:`WAKE_LO];
            `OFS_WAKE_EDGE0: next_s.wake_edge0 = wd[`WAKE_HI:`WAKE_LO];
            `OFS_RESET_STATUS: next_s.vmon_flag = s.vmon_flag & ~wd[`BIT_VMON2:`BIT_VMON0];
            `OFS_IRQ_STATUS: next_s.irq_status = s.irq_status & ~wd[2:0];
            `OFS_IRQ_MASK: next_s.irq_mask = wd[2:0];
            default: begin
            end
         endcase
      end

      // Hardware sets win over software clears.
      next_s.wake_flag0 = next_s.wake_flag0 | pin_wake;
      next_s.vmon_flag = next_s.vmon_flag | vmon_in;
      next_s.irq_status = next_s.irq_status | irq_ev;

      // Read mux, registered for the data phase answer.
      rd = 32'h0000_0000;
      unique case (haddr)
         `OFS_STOP_A: rd = s.stop_a;
         `OFS_STOP_B: rd = s.stop_b;
         `OFS_STOP_C: rd = s.stop_c;
         `OFS_DSBY_CTRL: rd[1:0] = s.deep_cut;
         `OFS_WAKE_EN0: rd[`WAKE_HI:`WAKE_LO] = s.wake_en0;
         `OFS_WAKE_EN1: rd[7:0] = s.wake_en1;
         `OFS_WAKE_EN2: rd[7:0] = s.wake_en2;
         `OFS_WAKE_EN3: rd[7:0] = s.wake_en3;
         `OFS_WAKE_FLAG0: rd[`WAKE_HI:`WAKE_LO] = s.wake_flag0;
         `OFS_WAKE_EDGE0: rd[`WAKE_HI:`WAKE_LO] = s.wake_edge0;
         `OFS_RESET_STATUS: rd[`BIT_VMON2:`BIT_VMON0] = s.vmon_flag;
         `OFS_IRQ_STATUS: rd[2:0] = s.irq_status;
         `OFS_IRQ_MASK: rd[2:0] = s.irq_mask;
         default: rd = 32'h0000_0000;
      endcase
      next_s.rdata = rd;

      // Clock enables follow the stop bits; a set bit freezes the peripheral,
      // its registers hold because only the clock is removed.
      next_s.en_a = ~next_s.stop_a;
      b_run = ~next_s.stop_b;
      next_s.en_b = b_run;
      next_s.en_c = ~next_s.stop_c;
      // Each CAN channel follows only its own bit; no cross term exists.
      next_s.en_b[`BIT_CAN0] = b_run[`BIT_CAN0];
      next_s.en_b[`BIT_CAN1] = b_run[`BIT_CAN1];
      next_s.mac_en = b_run[`BIT_MAC_DMA];
      next_s.dma_en = b_run[`BIT_MAC_DMA];
      // Standby RAM stays clocked only when its stop bit is clear.
      next_s.en_c[`BIT_SRAM] = ~next_s.stop_c[`BIT_SRAM];

      next_s.release_o = (|pin_wake) | other_wake;
      unique case (mstp_dsby_pkg::deep_cut_t'(next_s.deep_cut))
         mstp_dsby_pkg::CUT_KEEP: begin
            next_s.pwr_on = 1'b1;
            next_s.vdet_off = 1'b0;
            next_s.por_lp = 1'b0;
         end
         mstp_dsby_pkg::CUT_DEEP: begin
            next_s.pwr_on = 1'b0;
            next_s.vdet_off = 1'b1;
            next_s.por_lp = 1'b1;
         end
         default: begin
            next_s.pwr_on = 1'b0;
            next_s.vdet_off = 1'b0;
            next_s.por_lp = 1'b0;
         end
      endcase
      // The power cut applies only while deep standby is in effect.
      if (!deep_standby_active) begin
         next_s.pwr_on = 1'b1;
         next_s.vdet_off = 1'b0;
         next_s.por_lp = 1'b0;
      end
      next_s.irq_o = |(next_s.irq_status & next_s.irq_mask);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.stop_a <= `RST_STOP_A;
         s.stop_b <= `RST_STOP_B;
         s.stop_c <= `RST_STOP_C;
         s.pwr_on <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // The stop-bit writes to CAN need two CAN clocks before standby entry;
   // software times that, nothing here stalls for it.
   assign hrdata = s.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign clk_en_a = s.en_a;
   assign clk_en_b = s.en_b;
   assign clk_en_c = s.en_c;
   assign mac_clk_en = s.mac_en;
   assign mac_dma_clk_en = s.dma_en;
   assign deep_wake_release = s.release_o;
   assign sram_usb_power_on = s.pwr_on;
   assign vdet_stop = s.vdet_off;
   assign por_low_power = s.por_lp;
   assign irq = s.irq_o;
endmodule

// File: hdl/mstp_dsby_params.svh
`ifndef MSTP_DSBY_PARAMS_SVH
`define MSTP_DSBY_PARAMS_SVH
// Register byte offsets on the bus.
`define OFS_STOP_A 12'h000
`define OFS_STOP_B 12'h004
`define OFS_STOP_C 12'h008
`define OFS_DSBY_CTRL 12'h00C
`define OFS_WAKE_EN0 12'h010
`define OFS_WAKE_EN1 12'h014
`define OFS_WAKE_EN2 12'h018
`define OFS_WAKE_EN3 12'h01C
`define OFS_WAKE_FLAG0 12'h020
`define OFS_WAKE_EDGE0 12'h024
`define OFS_RESET_STATUS 12'h028
`define OFS_IRQ_STATUS 12'h02C
`define OFS_IRQ_MASK 12'h030
`define OFS_VMON_SET 12'h034
// Reset values.
`define RST_STOP_A 32'hFFFF_FFFF
`define RST_STOP_B 32'hFFFF_FFFF
`define RST_STOP_C 32'hFFFF_FFFF
// Field positions.
`define BIT_CAN0 0
`define BIT_CAN1 1
`define BIT_SCI12 4
`define BIT_DOC 6
`define BIT_TEMP 8
`define BIT_ELC 9
`define BIT_MAC_DMA 15
`define BIT_PDC 22
`define BIT_SCI7 24
`define BIT_SCI4 27
`define BIT_SRAM 7
`define BIT_IIC2 17
`define BIT_CAC 19
`define BIT_SPI2 22
`define BIT_QSPI 23
`define BIT_SCI11 24
`define BIT_SCI8 27
`define BIT_VMON0 1
`define BIT_VMON2 3
`define WAKE_LO 4
`define WAKE_HI 7
`endif

// File: hdl/mstp_dsby_pkg.sv
package mstp_dsby_pkg;
   typedef enum logic [1:0] {
      CUT_KEEP = 2'b00,
      CUT_OFF = 2'b01,
      CUT_BAD = 2'b10,
      CUT_DEEP = 2'b11
   } deep_cut_t;
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_WRITE = 2'b01,
      PH_READ = 2'b10
   } bus_phase_t;
endpackage

// File: hdl/pin_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for one asynchronous level.
module pin_sync (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic async_in,
   output logic sync_out
);
   typedef struct packed {
      logic meta;
      logic sync;
   } sync_state_t;
   sync_state_t s;
   sync_state_t next_s;
   always_comb begin
      next_s.meta = async_in;
      next_s.sync = s.meta;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign sync_out = s.sync;
endmodule

// File: hdl/wake_detect.sv
`timescale 1ns/1ps
// Edge detector for one synchronised wake pin; edge_sel high picks falling edge.
module wake_detect (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic pin_sync,
   input wire logic edge_sel,
   output logic event_pulse
);
   typedef struct packed {
      logic prev;
      logic pulse;
   } det_state_t;
   det_state_t s;
   det_state_t next_s;
   always_comb begin
      next_s.prev = pin_sync;
      next_s.pulse = edge_sel ? (s.prev & ~pin_sync) : (~s.prev & pin_sync);
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign event_pulse = s.pulse;
endmodule
